// File: logic/status_report_regs.svh
`ifndef STATUS_REPORT_REGS_SVH
`define STATUS_REPORT_REGS_SVH

// Status byte bit positions
`define SB_ERR_BIT      2
`define SB_EXT_BIT      3
`define SB_RESP_BIT     4
`define SB_STD_BIT      5
`define SB_MSS_BIT      6
// Standard event bit positions
`define SE_OPC_BIT      0
`define SE_QYE_BIT      2
`define SE_DEV_BIT      3
`define SE_EXE_BIT      4
`define SE_SYN_BIT      5
`define SE_PWR_BIT      7
// Bits that always read zero
`define SE_ZERO_MASK    8'h42
`define SB_ZERO_MASK    8'h83
// Reset values
`define ENABLE_RST      8'h00
`define STD_EVT_RST     8'h00

`endif

// File: logic/status_report_pkg.sv
`default_nettype none
package status_report_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_WR_SRE,
        CMD_WR_ESE,
        CMD_RD_STB,
        CMD_RD_ESR,
        CMD_RD_SRE,
        CMD_RD_ESE,
        CMD_CLS
    } cmd_e;
endpackage
`default_nettype wire

// File: logic/status_enable_reg.sv
`timescale 1ns/1ps
`default_nettype none
`include "status_report_regs.svh"

// Byte-wide enable mask, writable and readable; reading never alters it
module status_enable_reg #(
    parameter int WIDTH = 8
) (
    input  wire logic             mclk,   // Clock
    input  wire logic             rst_b,  // Async reset, active low
    input  wire logic             wrEn,   // Write strobe
    input  wire logic [WIDTH-1:0] wrData, // Write data
    input  wire logic [WIDTH-1:0] keep,   // Bits that are stored
    output logic      [WIDTH-1:0] value   // Stored mask
);
    logic [WIDTH-1:0] mask_ff;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mask_ff <= WIDTH'(`ENABLE_RST);
        end else if (wrEn) begin
            mask_ff <= wrData & keep;
        end
    end

    assign value = mask_ff;
endmodule
`default_nettype wire

// File: logic/status_byte_event_reporting.sv
`timescale 1ns/1ps
`default_nettype none
`include "status_report_regs.svh"

// Notes on behaviour
// RL1 - Each summary gated by its enable mask
// RL2 - Bit 2 follows error queue non-empty
// RL3 - Bit 3 is masked extended event OR
// RL4 - Bit 4 follows response queue non-empty
// RL5 - Bit 5 is masked standard event OR
// RL6 - Bit 6 master summary, enable bit6 ignored
// RL7 - Request flag: set on rise, clear poll/fall
// RL8 - Service request raised when bit 6 sets
// RL9 - Status query returns master summary, no clear
// RL10 - Serial poll shows flag, then clears it
// RL11 - Clear-status clears events and error queue; output queue only after terminator
// RL12 - Power-up event set at restart
// RL13 - Unused event and status bits read zero
// RL14 - Syntax error sets event bit 5
// RL15 - Execution error sets event bit 4
// RL16 - Internal error sets event bit 3
// RL17 - Query error sets event bit 2
// RL18 - Operation complete sets event bit 0
// RL19 - Controller clears enable bit to mask event
// RL20 - Controller clears enable bit to mask request
// RL21 - Event register read returns then clears
// RL22 - Event register cleared by read, clear, restart
// RL23 - Enable registers stored, queries do not alter
module status_byte_event_reporting #(
    parameter int EXT_WIDTH = 16
) (
    input  wire logic                 mclk,                  // 40 MHz clock
    input  wire logic                 rst_b,                 // Restart, active low
    input  wire logic [2:0]           cmdOp,                 // Command, cmd_e
    input  wire logic [7:0]           cmdData,               // Write value
    input  wire logic                 afterTerminator,       // Clear-status follows terminator
    input  wire logic                 serialPoll,            // Serial poll strobe
    input  wire logic                 errorQueueNonempty,    // Error queue holds entries
    input  wire logic                 responsePending,       // Output queue non-empty
    input  wire logic [EXT_WIDTH-1:0] extEvents,             // Extended event register
    input  wire logic [EXT_WIDTH-1:0] extEnable,             // Extended event enable
    input  wire logic                 syntaxErrorEvent,      // Syntax error pulse
    input  wire logic                 executionErrorEvent,   // Execution error pulse
    input  wire logic                 internalErrorEvent,    // Internal error pulse
    input  wire logic                 queryErrorEvent,       // Query error pulse
    input  wire logic                 operationCompleteEvent,// Operation done pulse
    output logic [7:0]                rdData,                // Read answer
    output logic                      rdValid,               // Read answer valid
    output logic                      serviceRequest,        // Request toward controller
    output logic                      clearOutputQueue,      // Output queue clear pulse
    output logic                      clearErrorQueue,       // Error queue clear pulse
    output logic [7:0]                statusByte             // Registered status byte, one cycle behind sources, MASTER_SUMMARY in bit 6
);
    status_report_pkg::cmd_e cmd;
    status_report_pkg::byte_t srEnable;
    status_report_pkg::byte_t seEnable;
    status_report_pkg::byte_t stdEvt_ff;
    status_report_pkg::byte_t nxt_stdEvt;
    status_report_pkg::byte_t evtSet;
    status_report_pkg::byte_t sbNoMss;
    status_report_pkg::byte_t sbFull;
    logic                     extSummary;
    logic                     stdSummary;
    logic                     masterSummary;
    logic                     mss_ff;
    logic                     rqs_ff;
    logic                     pwrUp_ff;
    logic [7:0]               rdData_ff;
    logic                     rdValid_ff;
    logic                     srq_ff;
    logic                     clrOut_ff;
    logic                     clrErr_ff;
    logic [7:0]               sb_ff;

    assign cmd = status_report_pkg::cmd_e'(cmdOp);

    status_enable_reg #(
        .WIDTH (8)
    ) u_sre (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .wrEn   (cmd == status_report_pkg::CMD_WR_SRE),
        .wrData (cmdData),
        .keep   (~(8'h01 << `SB_MSS_BIT)), // RL6
        .value  (srEnable)                 // RL23
    );

    status_enable_reg #(
        .WIDTH (8)
    ) u_ese (
        .mclk   (mclk),
        .rst_b  (rst_b),
        .wrEn   (cmd == status_report_pkg::CMD_WR_ESE),
        .wrData (cmdData),
        .keep   (8'hff),
        .value  (seEnable)                 // RL23
    );

    // Event sources mapped to their bit positions
    always_comb begin
        evtSet = 8'h00;
        evtSet[`SE_SYN_BIT] = syntaxErrorEvent;       // RL14
        evtSet[`SE_EXE_BIT] = executionErrorEvent;    // RL15
        evtSet[`SE_DEV_BIT] = internalErrorEvent;     // RL16
        evtSet[`SE_QYE_BIT] = queryErrorEvent;        // RL17
        evtSet[`SE_OPC_BIT] = operationCompleteEvent; // RL18
        evtSet[`SE_PWR_BIT] = pwrUp_ff;               // RL12
    end

    // Power-up marker, set during restart, cleared on the first edge after restart release
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pwrUp_ff <= 1'b1; // RL12
        end else begin
            pwrUp_ff <= 1'b0;
        end
    end

    // Clears by read or clear-status; a new event in the same cycle wins
    always_comb begin
        nxt_stdEvt = stdEvt_ff;
        if (cmd == status_report_pkg::CMD_RD_ESR || cmd == status_report_pkg::CMD_CLS) begin
            nxt_stdEvt = 8'h00; // RL21 RL22 RL11
        end
        nxt_stdEvt = (nxt_stdEvt | evtSet) & ~`SE_ZERO_MASK; // RL13
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stdEvt_ff <= `STD_EVT_RST; // RL22
        end else begin
            stdEvt_ff <= nxt_stdEvt;
        end
    end

    assign extSummary = |(extEvents & extEnable); // RL3 RL1
    assign stdSummary = |(stdEvt_ff & seEnable);  // RL5 RL1

    always_comb begin
        sbNoMss = 8'h00;
        sbNoMss[`SB_ERR_BIT]  = errorQueueNonempty; // RL2
        sbNoMss[`SB_EXT_BIT]  = extSummary;
        sbNoMss[`SB_RESP_BIT] = responsePending;    // RL4
        sbNoMss[`SB_STD_BIT]  = stdSummary;
        sbNoMss = sbNoMss & ~`SB_ZERO_MASK;         // RL13
    end

    assign masterSummary = |(sbNoMss & srEnable); // RL6 RL1

    always_comb begin
        sbFull = sbNoMss;
        sbFull[`SB_MSS_BIT] = masterSummary; // RL9
    end

    // Request flag: rise sets, poll or fall clears; a rise beats a poll
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mss_ff <= 1'b0;
            rqs_ff <= 1'b0;
        end else begin
            mss_ff <= masterSummary;
            if (masterSummary && !mss_ff) begin
                rqs_ff <= 1'b1;  // RL7
            end else if (!masterSummary || serialPoll) begin
                rqs_ff <= 1'b0;  // RL7 RL10
            end
        end
    end

    // Service request line follows the request flag
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            srq_ff <= 1'b0;
        end else begin
            srq_ff <= (masterSummary && !mss_ff) || (rqs_ff && masterSummary && !serialPoll); // RL8
        end
    end

    // Read answers, registered one cycle after the command
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdData_ff  <= 8'h00;
            rdValid_ff <= 1'b0;
        end else begin
            rdValid_ff <= 1'b1;
            if (serialPoll) begin
                rdData_ff <= {sbNoMss[7], rqs_ff, sbNoMss[5:0]}; // RL10
            end else begin
                case (cmd)
                    status_report_pkg::CMD_RD_STB: rdData_ff <= sbFull;    // RL9
                    status_report_pkg::CMD_RD_ESR: rdData_ff <= stdEvt_ff; // RL21
                    status_report_pkg::CMD_RD_SRE: rdData_ff <= srEnable;  // RL23
                    status_report_pkg::CMD_RD_ESE: rdData_ff <= seEnable;  // RL23
                    default: begin
                        rdValid_ff <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Queue clears requested by clear-status
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            clrOut_ff <= 1'b0;
            clrErr_ff <= 1'b0;
        end else begin
            clrErr_ff <= (cmd == status_report_pkg::CMD_CLS);
            clrOut_ff <= (cmd == status_report_pkg::CMD_CLS) && afterTerminator; // RL11
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sb_ff <= 8'h00;
        end else begin
            sb_ff <= sbFull;
        end
    end

    assign rdData           = rdData_ff;
    assign rdValid          = rdValid_ff;
    assign serviceRequest   = srq_ff;
    assign clearOutputQueue = clrOut_ff;
    assign clearErrorQueue  = clrErr_ff;
    assign statusByte       = sb_ff;
endmodule
`default_nettype wire

// File: test/status_report_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module status_report_checker #(parameter int EXT_WIDTH = 16) (
    input wire logic mclk, rst_b, afterTerminator, serialPoll, errorQueueNonempty,
    input wire logic responsePending, rdValid, serviceRequest, clearOutputQueue,
    input wire logic clearErrorQueue,
    input wire logic [2:0] cmdOp,
    input wire logic [7:0] rdData, statusByte,
    input wire logic [EXT_WIDTH-1:0] extEvents, extEnable
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_zero_bits: assert property ((statusByte & 8'h83) == 8'h00)
        else $error("unused status bits set");
    a_err_bit: assert property ($past(rst_b) |-> statusByte[2] == $past(errorQueueNonempty))
        else $error("error bit wrong");
    a_resp_bit: assert property ($past(rst_b) |-> statusByte[4] == $past(responsePending))
        else $error("response bit wrong");
    a_ext_bit: assert property ($past(rst_b) |-> statusByte[3] == |$past(extEvents & extEnable))
        else $error("extended summary wrong");
    a_req_rise: assert property ($past(rst_b) && $rose(statusByte[6]) |-> serviceRequest)
        else $error("no request on summary rise");
    a_req_drop: assert property (!statusByte[6] |-> !serviceRequest)
        else $error("request without summary");
    a_poll_ans: assert property (serialPoll |=> rdValid && rdData[6] == $past(serviceRequest))
        else $error("poll answer wrong");
    a_poll_clr: assert property (serialPoll |=> !serviceRequest || $rose(statusByte[6]))
        else $error("poll left request set");
    a_stb_read: assert property (cmdOp == status_report_pkg::CMD_RD_STB && !serialPoll
        |=> rdValid && rdData == statusByte)
        else $error("status query answer wrong");
    a_cls_pulse: assert property (cmdOp == status_report_pkg::CMD_CLS
        |=> clearErrorQueue && clearOutputQueue == $past(afterTerminator))
        else $error("clear pulses wrong");
endmodule
bind status_byte_event_reporting status_report_checker #(.EXT_WIDTH(EXT_WIDTH)) u_chk (
    .mclk, .rst_b, .afterTerminator, .serialPoll, .errorQueueNonempty, .responsePending,
    .rdValid, .serviceRequest, .clearOutputQueue, .clearErrorQueue, .cmdOp, .rdData,
    .statusByte, .extEvents, .extEnable);
`default_nettype wire

// File: test/status_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module status_host_model (
    input  wire logic       mclk,            // Clock
    input  wire logic [7:0] rdData,          // Answer byte
    input  wire logic       rdValid,         // Answer strobe
    output logic      [2:0] cmdOp,           // Command
    output logic      [7:0] cmdData,         // Write value
    output logic            afterTerminator, // Clear follows terminator
    output logic            serialPoll       // Poll strobe
);
    initial begin
        cmdOp = 3'h0;
        cmdData = 8'h00;
        afterTerminator = 1'b0;
        serialPoll = 1'b0;
    end
    // One command or poll per call; answer taken one edge later
    task automatic send(input logic [2:0] op, input logic [7:0] d, input logic poll,
                        output logic [7:0] v);
        cmdOp = op;
        cmdData = d;
        serialPoll = poll;
        @(posedge mclk);
        #2;
        v = (rdValid === 1'b1) ? rdData : 8'hxx;
        cmdOp = 3'h0;
        cmdData = ~d;
        serialPoll = 1'b0;
        // Idle edge so the next call never reassigns in this time step
        @(posedge mclk);
        #2;
    endtask
endmodule
`default_nettype wire

// File: test/status_byte_event_reporting_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module status_byte_event_reporting_tb_top;
    localparam logic [2:0] WSRE = status_report_pkg::CMD_WR_SRE;
    localparam logic [2:0] WESE = status_report_pkg::CMD_WR_ESE;
    localparam logic [2:0] RSTB = status_report_pkg::CMD_RD_STB;
    localparam logic [2:0] RESR = status_report_pkg::CMD_RD_ESR;
    localparam logic [2:0] RSRE = status_report_pkg::CMD_RD_SRE;
    localparam logic [2:0] RESE = status_report_pkg::CMD_RD_ESE;
    localparam logic [2:0] CLS  = status_report_pkg::CMD_CLS;
    localparam logic [7:0] EBIT [5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h01};
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic [2:0]  cmdOp;
    logic [7:0]  cmdData, rdData, statusByte, v;
    logic        afterTerminator, serialPoll, rdValid, serviceRequest, eq, rp;
    logic [4:0]  evt;
    logic [15:0] extEvents, extEnable;
    int          num_errors = 0, compares = 0, cycles = 0;
    always #12.5 mclk = ~mclk;
    status_host_model u_host (.mclk, .rdData, .rdValid, .cmdOp, .cmdData, .afterTerminator,
        .serialPoll);
    status_byte_event_reporting u_dut (.mclk, .rst_b, .cmdOp, .cmdData, .afterTerminator,
        .serialPoll, .errorQueueNonempty(eq), .responsePending(rp), .extEvents, .extEnable,
        .syntaxErrorEvent(evt[0]), .executionErrorEvent(evt[1]), .internalErrorEvent(evt[2]),
        .queryErrorEvent(evt[3]), .operationCompleteEvent(evt[4]), .rdData, .rdValid,
        .serviceRequest, .clearOutputQueue(), .clearErrorQueue(), .statusByte);
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic pulse(input logic [4:0] m);
        evt = m;
        step(1);
        evt = 5'h00;
        step(2);
    endtask
    task automatic give_verdict();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        {evt, eq, rp, extEvents, extEnable} = '0;
        repeat (4) @(posedge mclk);
        #2 rst_b = 1'b1;
        step(2);
        u_host.send(RESR, 8'h00, 1'b0, v); chk("esr power-up", 8'h80, v);
        u_host.send(RESR, 8'h00, 1'b0, v); chk("esr after read", 8'h00, v);
        for (int i = 0; i < 5; i++) begin
            pulse(5'h01 << i);
            u_host.send(RESR, 8'h00, 1'b0, v); chk("esr event", EBIT[i], v);
        end
        $display("events test done");
        u_host.send(WESE, 8'hff, 1'b0, v);
        u_host.send(WSRE, 8'hff, 1'b0, v);
        u_host.send(RSRE, 8'h00, 1'b0, v); chk("sre read", 8'hbf, v);
        u_host.send(RESE, 8'h00, 1'b0, v); chk("ese read", 8'hff, v);
        u_host.send(WESE, 8'h20, 1'b0, v);
        pulse(5'h02);
        chk("masked event", 8'h00, statusByte);
        pulse(5'h01);
        chk("event summary", 8'h60, statusByte);
        chk("request", 8'h01, serviceRequest);
        u_host.send(RSTB, 8'h00, 1'b0, v); chk("stb query", 8'h60, v);
        chk("stb after query", 8'h60, statusByte);
        u_host.send(3'h0, 8'h00, 1'b1, v); chk("poll byte", 8'h60, v);
        chk("request after poll", 8'h00, serviceRequest);
        u_host.send(3'h0, 8'h00, 1'b1, v); chk("second poll", 8'h20, v);
        $display("request test done");
        u_host.send(CLS, 8'h00, 1'b0, v);
        step(1);
        chk("after clear", 8'h00, statusByte);
        u_host.send(RESR, 8'h00, 1'b0, v); chk("esr after clear", 8'h00, v);
        u_host.afterTerminator = 1'b1;
        u_host.send(CLS, 8'h00, 1'b0, v);
        u_host.afterTerminator = 1'b0;
        $display("clear test done");
        u_host.send(WSRE, 8'h04, 1'b0, v);
        rp = 1'b1;
        step(2);
        chk("response bit", 8'h10, statusByte);
        chk("masked request", 8'h00, serviceRequest);
        eq = 1'b1;
        extEvents = 16'h0100;
        step(2);
        chk("error bit", 8'h54, statusByte);
        chk("error request", 8'h01, serviceRequest);
        extEnable = 16'h0100;
        step(2);
        chk("extended bit", 8'h5c, statusByte);
        eq = 1'b0;
        step(2);
        chk("summary fall", 8'h18, statusByte);
        chk("request fall", 8'h00, serviceRequest);
        $display("inputs test done");
        give_verdict();
    end
endmodule
`default_nettype wire
